// ### gcs_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the chop sequencer
// Assumes: avalon word addressing is byte address / 4 of the printed index
// Notes:   definitions only
`ifndef GCS_MAP_SVH
`define GCS_MAP_SVH

// ----------------------------------------
// register indices and address width
// ----------------------------------------
`define GCS_IDX_GAIN        4'h3
`define GCS_IDX_DATARATE    4'h4
`define GCS_IDX_EXC1        4'h6
`define GCS_IDX_EXC2        4'h7
`define GCS_IDX_CTRL        4'h8
`define GCS_IDX_STAT        4'h9
`define GCS_IDX_RESULT      4'ha
`define GCS_ADDR_W          6

// ----------------------------------------
// field positions
// ----------------------------------------
`define GCS_DELAY_LSB       5
`define GCS_DELAY_W         3
`define GCS_CHOP_BIT        5
`define GCS_RATE_W          4
`define GCS_MAG_W           4
`define GCS_ROUTE_W         4
`define GCS_RESULT_W        16

// ----------------------------------------
// reset values
// ----------------------------------------
`define GCS_GAIN_RST        8'h00
`define GCS_DATARATE_RST    8'h14
`define GCS_EXC1_RST        8'h00
`define GCS_EXC2_RST        8'hff

// ----------------------------------------
// timing
// ----------------------------------------
`define GCS_CLK_PER_MOD     16
`define GCS_DELAY_DEFAULT   28
`define GCS_SCLK_START_EDGE 7
`define GCS_FIRST_4000      464
`define GCS_NEXT_4000       232
`define GCS_FIRST_2P5       614530
`define GCS_CNT_W           24

`endif

// ### gcs_pkg.sv
// Purpose: types for the chop sequencer
// Assumes: nothing
// Notes:   constants live in gcs_map.svh
package gcs_pkg;

  typedef enum logic [2:0] {
    GCS_IDLE   = 3'b000,
    GCS_CONV   = 3'b001,
    GCS_DELAY  = 3'b011,
    GCS_AVG    = 3'b010
  } gcs_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } gcs_bus_req_t;

  typedef struct packed {
    logic [3:0] magnitude;
    logic [3:0] route_one;
    logic [3:0] route_two;
    logic       enable;
  } gcs_exc_t;

endpackage

// ### gcs_sequencer.sv
// Purpose: global chop conversion sequencer with excitation source configuration
// Assumes: pins synchronous to clk; modulator supplies one raw sample per conversion
// Notes:   avalon-mm slave with waitrequest, one wait cycle on every access
//
// Overview of operation
// - a conversion starts on a trigger pin rising edge or on the seventh sclk falling edge of a start command.
// - a modulator period is 16 clocks and the default delay adds 28 modulator periods.
// - the settling delay is applied to both conversions of a chopped pair.
// - sinc3 chop timing uses fixed first and later lengths per rate, 464/232 at 4000 sps and 614530 first at 2.5 sps.
// - the input polarity reverses after the first data and swaps on every following conversion.
// - each result is the average of the last two opposite polarity conversions.
// - the filter is allowed to settle after each reversal without changing the notch timing.
// - two matched excitation sources share a four-bit magnitude in excitation register 1.
// - each source has its own four-bit routing field in excitation register 2.
// - both sources on the same pin is accepted and not an error.
// - one bit of the data rate register switches global chop on and off.
// - in continuous chop, each later result takes half the first result time.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "gcs_map.svh"

module gcs_sequencer (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [`GCS_ADDR_W-1:0]     avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       start_pin,
  input  wire logic                       sclk,
  input  wire logic                       start_cmd_active,
  input  wire logic                       reference_on,
  input  wire logic                       continuous,
  input  wire logic [`GCS_RESULT_W-1:0]   raw_sample,
  output logic                            input_reversed,
  output logic                            converting,
  output logic                            result_valid,
  output logic      [`GCS_RESULT_W-1:0]   result,
  output logic      [3:0]                 excitation_magnitude_field,
  output logic      [3:0]                 source_one_route_field,
  output logic      [3:0]                 source_two_route_field,
  output logic                            excitation_enable
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // first-result length in modulator periods; later results are half of it
  function automatic logic [`GCS_CNT_W-1:0] first_len(input logic [3:0] rate);
    first_len = 24'd0;
    case (rate)
      4'h0:    first_len = 24'(`GCS_FIRST_2P5);
      4'h1:    first_len = 24'd307330;
      4'h2:    first_len = 24'd153730;
      4'h3:    first_len = 24'd92290;
      4'h4:    first_len = 24'd76930;
      4'h5:    first_len = 24'd30850;
      4'h6:    first_len = 24'd25714;
      4'h7:    first_len = 24'd15490;
      4'h8:    first_len = 24'd7810;
      4'h9:    first_len = 24'd3970;
      4'ha:    first_len = 24'd2050;
      4'hb:    first_len = 24'd1616;
      4'hc:    first_len = 24'd848;
      default: first_len = 24'(`GCS_FIRST_4000);
    endcase
  endfunction

  // delay field code to modulator periods, code 0 is the default 28
  function automatic logic [`GCS_CNT_W-1:0] delay_len(input logic [2:0] code);
    delay_len = 24'd0;
    case (code)
      3'h0:    delay_len = 24'(`GCS_DELAY_DEFAULT);
      3'h1:    delay_len = 24'd64;
      3'h2:    delay_len = 24'd256;
      3'h3:    delay_len = 24'd1024;
      3'h4:    delay_len = 24'd2048;
      3'h5:    delay_len = 24'd4096;
      3'h6:    delay_len = 24'd1;
      default: delay_len = 24'd0;
    endcase
  endfunction

  // ----------------------------------------
  // registers and bus
  // ----------------------------------------
  logic [7:0]  gain_reg, next_gain_reg;
  logic [7:0]  rate_reg, next_rate_reg;
  logic [7:0]  exc1_reg, next_exc1_reg;
  logic [7:0]  exc2_reg, next_exc2_reg;
  logic        waited, next_waited;
  logic [31:0] next_readdata;
  logic        start_evt;
  logic        overrun, next_overrun;
  logic        bus_active;
  logic        wr_take;
  logic [3:0]  idx;
  gcs_pkg::gcs_exc_t exc_view;

  assign bus_active = avs_read | avs_write;
  assign idx        = avs_address[3:0];
  assign wr_take    = avs_write & waited;
  assign exc_view   = '{magnitude: exc1_reg[3:0], route_one: exc2_reg[3:0],
                        route_two: exc2_reg[7:4], enable: reference_on};

  always_comb begin
    next_waited   = bus_active & ~waited;
    next_gain_reg = gain_reg;
    next_rate_reg = rate_reg;
    next_exc1_reg = exc1_reg;
    next_exc2_reg = exc2_reg;
    next_readdata = avs_readdata;
    if (wr_take) begin
      case (idx)
        `GCS_IDX_GAIN:     next_gain_reg = avs_writedata[7:0];
        `GCS_IDX_DATARATE: next_rate_reg = avs_writedata[7:0];
        `GCS_IDX_EXC1:     next_exc1_reg = avs_writedata[7:0];
        // any route pair is accepted, even both on one pin
        `GCS_IDX_EXC2:     next_exc2_reg = avs_writedata[7:0];
        default:           next_gain_reg = gain_reg;
      endcase
    end
    if (avs_read & ~waited) begin
      case (idx)
        `GCS_IDX_GAIN:     next_readdata = {24'h0, gain_reg};
        `GCS_IDX_DATARATE: next_readdata = {24'h0, rate_reg};
        `GCS_IDX_EXC1:     next_readdata = {24'h0, exc1_reg};
        `GCS_IDX_EXC2:     next_readdata = {24'h0, exc2_reg};
        `GCS_IDX_STAT:     next_readdata = {28'h0, overrun, input_reversed,
                                            converting, result_valid};
        `GCS_IDX_RESULT:   next_readdata = {16'h0, result};
        default:           next_readdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gain_reg     <= `GCS_GAIN_RST;
      rate_reg     <= `GCS_DATARATE_RST;
      exc1_reg     <= `GCS_EXC1_RST;
      exc2_reg     <= `GCS_EXC2_RST;
      waited       <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      gain_reg     <= next_gain_reg;
      rate_reg     <= next_rate_reg;
      exc1_reg     <= next_exc1_reg;
      exc2_reg     <= next_exc2_reg;
      waited       <= next_waited;
      avs_readdata <= next_readdata;
    end
  end

  // waitrequest is high until the access has had its one wait cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_active & ~waited);
    end
  end

  // ----------------------------------------
  // start detection
  // ----------------------------------------
  logic       pin_q, sclk_q;
  logic [2:0] sclk_falls, next_sclk_falls;

  always_comb begin
    next_sclk_falls = sclk_falls;
    if (!start_cmd_active) begin
      next_sclk_falls = 3'h0;
    end else if (sclk_q & ~sclk & (sclk_falls != 3'h7)) begin
      next_sclk_falls = sclk_falls + 3'h1;
    end
  end

  // trigger on pin rise, or on the falling edge that makes the count seven
  assign start_evt = (start_pin & ~pin_q) |
                     (start_cmd_active & sclk_q & ~sclk &
                      (sclk_falls == 3'(`GCS_SCLK_START_EDGE - 1)));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q      <= 1'b0;
      sclk_q     <= 1'b0;
      sclk_falls <= 3'h0;
    end else begin
      pin_q      <= start_pin;
      sclk_q     <= sclk;
      sclk_falls <= next_sclk_falls;
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  gcs_pkg::gcs_state_t state, next_state;
  logic [`GCS_CNT_W-1:0] mod_left, next_mod_left;
  logic [3:0]            clk_div, next_clk_div;
  logic                  first_done, next_first_done;
  logic                  have_prev, next_have_prev;
  logic                  next_reversed, next_converting, next_result_valid;
  logic [`GCS_RESULT_W:0]   prev_sample, next_prev_sample;
  logic [`GCS_RESULT_W-1:0] next_result;
  logic                  chop_on;
  logic                  mod_tick;
  logic [`GCS_CNT_W-1:0] conv_len;
  logic [`GCS_RESULT_W+1:0] pair_sum;
  logic [`GCS_RESULT_W:0]   signed_now;

  assign chop_on  = rate_reg[`GCS_CHOP_BIT];
  assign mod_tick = (clk_div == 4'(`GCS_CLK_PER_MOD - 1));
  // a chopped conversion is half a first result, so later results take half its time
  assign conv_len   = (chop_on | first_done) ? (first_len(rate_reg[3:0]) >> 1) :
                                               first_len(rate_reg[3:0]);
  // negate in a wider word so the most negative sample cannot wrap
  assign signed_now = input_reversed ? (17'h0 - {raw_sample[15], raw_sample}) :
                                       {raw_sample[15], raw_sample};
  assign pair_sum   = {signed_now[16], signed_now} + {prev_sample[16], prev_sample};

  always_comb begin
    next_state        = state;
    next_mod_left     = mod_left;
    next_clk_div      = mod_tick ? 4'h0 : clk_div + 4'h1;
    next_first_done   = first_done;
    next_have_prev    = have_prev;
    next_reversed     = input_reversed;
    next_converting   = converting;
    next_result_valid = 1'b0;
    next_prev_sample  = prev_sample;
    next_result       = result;
    next_overrun      = overrun | (start_evt & converting);
    case (state)
      gcs_pkg::GCS_IDLE: begin
        next_first_done = 1'b0;
        next_have_prev  = 1'b0;
        next_reversed   = 1'b0;
        if (start_evt) begin
          next_state      = gcs_pkg::GCS_DELAY;
          // settling delay precedes every conversion, so twice per pair
          next_mod_left   = delay_len(gain_reg[7:5]);
          next_converting = 1'b1;
          next_clk_div    = 4'h0;
        end
      end
      gcs_pkg::GCS_DELAY: begin
        // filter settles here after each reversal; rate timing unchanged
        // a zero delay leaves after one cycle instead of a whole period
        if ((mod_left == 24'd0) | (mod_tick & (mod_left <= 24'd1))) begin
          next_state    = gcs_pkg::GCS_CONV;
          next_mod_left = conv_len;
        end else if (mod_tick) begin
          next_mod_left = mod_left - 24'd1;
        end
      end
      gcs_pkg::GCS_CONV: begin
        if (mod_tick) begin
          if (mod_left <= 24'd1) begin
            next_state = gcs_pkg::GCS_AVG;
          end else begin
            next_mod_left = mod_left - 24'd1;
          end
        end
      end
      gcs_pkg::GCS_AVG: begin
        next_prev_sample = signed_now;
        next_have_prev   = 1'b1;
        next_first_done  = 1'b1;
        if (!chop_on) begin
          next_result       = raw_sample;
          next_result_valid = 1'b1;
        end else if (have_prev) begin
          next_result       = pair_sum[`GCS_RESULT_W:1];
          next_result_valid = 1'b1;
        end
        // a chopped single shot still runs its reversed partner conversion
        if (continuous | (chop_on & ~have_prev)) begin
          next_state    = gcs_pkg::GCS_DELAY;
          next_mod_left = delay_len(gain_reg[7:5]);
          // swap polarity for the next conversion of the sequence
          next_reversed = chop_on ? ~input_reversed : 1'b0;
        end else begin
          next_state      = gcs_pkg::GCS_IDLE;
          next_converting = 1'b0;
          next_reversed   = 1'b0;
        end
      end
      default: next_state = gcs_pkg::GCS_IDLE;
    endcase
    if (wr_take & (idx == `GCS_IDX_STAT)) begin
      next_overrun = (start_evt & converting);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state          <= gcs_pkg::GCS_IDLE;
      mod_left       <= 24'd0;
      clk_div        <= 4'h0;
      first_done     <= 1'b0;
      have_prev      <= 1'b0;
      input_reversed <= 1'b0;
      converting     <= 1'b0;
      result_valid   <= 1'b0;
      prev_sample    <= 17'h0;
      result         <= 16'h0;
      overrun        <= 1'b0;
    end else begin
      state          <= next_state;
      mod_left       <= next_mod_left;
      clk_div        <= next_clk_div;
      first_done     <= next_first_done;
      have_prev      <= next_have_prev;
      input_reversed <= next_reversed;
      converting     <= next_converting;
      result_valid   <= next_result_valid;
      prev_sample    <= next_prev_sample;
      result         <= next_result;
      overrun        <= next_overrun;
    end
  end

  // ----------------------------------------
  // excitation outputs
  // ----------------------------------------
  // sources idle while the reference is off; caller must turn it on
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      excitation_magnitude_field <= 4'h0;
      source_one_route_field     <= 4'hf;
      source_two_route_field     <= 4'hf;
      excitation_enable          <= 1'b0;
    end else begin
      excitation_magnitude_field <= exc_view.magnitude;
      source_one_route_field     <= exc_view.route_one;
      source_two_route_field     <= exc_view.route_two;
      excitation_enable          <= exc_view.enable & (exc_view.magnitude != 4'h0);
    end
  end

endmodule

// ### gcs_seq_monitor.sv
// Purpose: port assertions for the chop sequencer
// Assumes: one clock, async active high reset
// Notes:   bound onto gcs_sequencer
`timescale 1ns/100ps
`include "gcs_map.svh"
module gcs_seq_monitor (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     avs_read,
  input wire logic                     avs_write,
  input wire logic                     avs_waitrequest,
  input wire logic                     start_pin,
  input wire logic                     reference_on,
  input wire logic                     input_reversed,
  input wire logic                     converting,
  input wire logic                     result_valid,
  input wire logic [`GCS_RESULT_W-1:0] result,
  input wire logic [3:0]               excitation_magnitude_field,
  input wire logic                     excitation_enable
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence bus_ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_answer_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer not one wait cycle");
  bus_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  start_pin_a: assert property ($rose(start_pin) && !converting |-> ##[1:4] converting)
    else $error("pin rise did not start conversion");
  valid_pulse_a: assert property (result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  result_hold_a: assert property (!result_valid |-> $stable(result))
    else $error("result changed without valid");
  result_conv_a: assert property (result_valid |-> $past(converting))
    else $error("result outside conversion");
  polarity_hold_a: assert property ($rose(input_reversed) |=> input_reversed [*8])
    else $error("reversal did not hold");
  flip_conv_a: assert property ($changed(input_reversed) |-> $past(converting))
    else $error("polarity moved while idle");
  exc_ref_a: assert property (!reference_on [*3] |-> !excitation_enable)
    else $error("sources on without reference");
  exc_zero_a: assert property ((excitation_magnitude_field == 4'h0) [*2] |-> !excitation_enable)
    else $error("sources on at zero magnitude");
endmodule

bind gcs_sequencer gcs_seq_monitor gcs_seq_monitor_inst (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .start_pin(start_pin), .reference_on(reference_on),
  .input_reversed(input_reversed), .converting(converting), .result_valid(result_valid),
  .result(result), .excitation_magnitude_field(excitation_magnitude_field),
  .excitation_enable(excitation_enable));

// ### gcs_host_model.sv
// Purpose: host side starting conversions by pin or serial command
// Assumes: go requests are one clock wide and spaced by the bench
// Notes:   sclk stands low outside command frames
`timescale 1ns/100ps
module gcs_host_model (
  input  wire logic clk,
  input  wire logic go_pin,
  input  wire logic go_cmd,
  output logic      start_pin,
  output logic      sclk,
  output logic      start_cmd_active
);
  // one process owns every output, so each has a single driver
  initial begin
    start_pin        = 1'b0;
    sclk             = 1'b0;
    start_cmd_active = 1'b0;
    forever begin
    @(posedge clk);
    if (go_pin) begin
      start_pin <= 1'b1;
      repeat (4) @(posedge clk);
      start_pin <= 1'b0;
    end
    if (go_cmd) begin
      start_cmd_active <= 1'b1;
      // eight clocks sent whole; the seventh fall is the start
      for (int i = 0; i < 8; i++) begin
        repeat (4) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      start_cmd_active <= 1'b0;
    end
    end
  end
endmodule

// ### gcs_sequencer_bench.sv
// Purpose: self-checking bench for the chop sequencer
// Assumes: rate code 13 without chop, then with chop at delay codes 7 and 0
// Notes:   expected values come from the bench functions
`timescale 1ns/100ps
`include "gcs_map.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module gcs_sequencer_bench;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  adr = '0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = '0;
  logic        go_pin = 1'b0;
  logic        go_cmd = 1'b0;
  logic        ref_on = 1'b0;
  logic        cont = 1'b0;
  logic [15:0] raw = '0;
  logic        sclk_q = 1'b0;
  logic [31:0] seed = 32'h29;
  logic [3:0]  ra [5] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h2};
  logic [7:0]  rx [5] = '{`GCS_GAIN_RST, `GCS_DATARATE_RST, `GCS_EXC1_RST, `GCS_EXC2_RST, 8'h00};
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          falls = 0;
  wire  [31:0] rdata;
  wire  [15:0] res;
  wire  [3:0]  mag, r1, r2;
  wire         wreq, spin, sclk, scmd, rev, conv, rv, een;

  gcs_sequencer gcs_sequencer_inst (
    .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdata), .avs_waitrequest(wreq), .start_pin(spin),
    .sclk(sclk), .start_cmd_active(scmd), .reference_on(ref_on), .continuous(cont),
    .raw_sample(raw), .input_reversed(rev), .converting(conv), .result_valid(rv),
    .result(res), .excitation_magnitude_field(mag), .source_one_route_field(r1),
    .source_two_route_field(r2), .excitation_enable(een));
  gcs_host_model gcs_host_model_inst (
    .clk(clk), .go_pin(go_pin), .go_cmd(go_cmd), .start_pin(spin), .sclk(sclk),
    .start_cmd_active(scmd));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sclk_q <= sclk;
    if (sclk_q && !sclk) falls <= falls + 1;
    if (cyc == 90000) begin
      err_count++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // tasks and functions
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // negate the reversed sample, halve at result width
  function automatic logic [15:0] avg(input logic [15:0] nrm, input logic [15:0] rvs);
    logic signed [16:0] s;
    s = $signed({nrm[15], nrm}) - $signed({rvs[15], rvs});
    return s[16:1];
  endfunction
  task acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= {2'h0, a};
    wd <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) err_count++;
  endtask
  task wait_rv(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rv !== 1'b1 && n < 20000);
    if (n >= 20000) err_count++;
  endtask
  task pulse(input logic p);
    go_pin <= p;
    go_cmd <= !p;
    @(posedge clk);
    go_pin <= 1'b0;
    go_cmd <= 1'b0;
  endtask
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic [15:0] v;
    logic [15:0] vals [$];
    logic        pr;
    logic [3:0]  t;
    int          n;
    int          f0;
    int          base;
    int          lo;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, ra[i], 8'h00, q);
      `CHK("reset value", {24'h0, rx[i]}, q)
    end
    $display("register reset test done");
    for (int k = 0; k < 4; k++) begin
      v = 16'(xs());
      ref_on <= k[0];
      acc(1'b1, `GCS_IDX_EXC1, {4'h0, v[3:0] | 4'h1}, q);
      t = k[1] ? v[7:4] : v[11:8];
      acc(1'b1, `GCS_IDX_EXC2, {t, v[7:4]}, q);
      acc(1'b0, `GCS_IDX_EXC2, 8'h00, q);
      `CHK("route readback", {24'h0, t, v[7:4]}, q)
      `CHK("magnitude", v[3:0] | 4'h1, mag)
      `CHK("route one", v[7:4], r1)
      `CHK("route two", t, r2)
      `CHK("source enable", k[0], een)
    end
    acc(1'b1, `GCS_IDX_EXC1, 8'h00, q);
    acc(1'b0, `GCS_IDX_EXC1, 8'h00, q);
    `CHK("enable at zero", 1'b0, een)
    $display("excitation test done");
    acc(1'b1, `GCS_IDX_GAIN, 8'he0, q);
    acc(1'b1, `GCS_IDX_DATARATE, 8'h0d, q);
    v = 16'(xs());
    raw <= v;
    f0 = falls;
    pulse(1'b0);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (conv !== 1'b1 && n < 200);
    `CHK("falls at start", 7, falls - f0)
    // let the host finish its frame, then start again while converting
    repeat (20) @(posedge clk);
    pulse(1'b1);
    acc(1'b0, `GCS_IDX_STAT, 8'h00, q);
    `CHK("status overrun", 32'ha, q)
    acc(1'b1, `GCS_IDX_STAT, 8'h00, q);
    acc(1'b0, `GCS_IDX_STAT, 8'h00, q);
    `CHK("status cleared", 32'h2, q)
    wait_rv(n);
    `CHK("plain result", v, res)
    $display("command start test done");
    for (int d = 0; d < 2; d++) begin
      acc(1'b1, `GCS_IDX_GAIN, d ? 8'h00 : 8'he0, q);
      acc(1'b1, `GCS_IDX_DATARATE, 8'h2d, q);
      base = (`GCS_NEXT_4000 + d * `GCS_DELAY_DEFAULT) * `GCS_CLK_PER_MOD;
      vals.delete();
      v = 16'(xs());
      vals.push_back(v);
      raw <= v;
      cont <= 1'b1;
      pulse(1'b1);
      for (int k = 1; k <= 4; k++) begin
        wait_rv(n);
        lo = (k == 1) ? 2 * base : base;
        `CHK("result time", 1'b1, n >= lo && n <= lo + 12)
        `CHK("average", avg(vals[k[0] ? (k > 1 ? k - 2 : 0) : k - 1],
          vals[k[0] ? k - 1 : k - 2]), res)
        if (k > 1) `CHK("polarity swap", !pr, rev)
        pr = rev;
        v = 16'(xs());
        vals.push_back(v);
        raw <= v;
      end
      cont <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (conv !== 1'b0 && n < 20000);
      $display("chop test with delay code %0d done", d ? 0 : 7);
    end
    report_and_stop();
  end
endmodule
